/* File: hw/slsc_pkg.sv */
// package for the serial link sync control block
// assumes a 32-bit apb slave with word-aligned registers
package slsc_pkg;
  // printed offsets are indices, not byte addresses (0x20F and 0x215 are not multiples of four): byte address = 4 * index
  localparam logic [11:0] IDX_SYNC_HEADER_MODE = 12'h20F;
  localparam logic [11:0] IDX_SYNC_REQUEST_THRESHOLD = 12'h210;
  localparam logic [11:0] IDX_LINK_CTRL = 12'h214;
  localparam logic [11:0] IDX_LINK_STATUS = 12'h215;
  localparam logic [13:0] ADDR_SYNC_HEADER_MODE = {IDX_SYNC_HEADER_MODE, 2'b00};
  localparam logic [13:0] ADDR_SYNC_REQUEST_THRESHOLD = {IDX_SYNC_REQUEST_THRESHOLD, 2'b00};
  localparam logic [13:0] ADDR_LINK_CTRL = {IDX_LINK_CTRL, 2'b00};
  localparam logic [13:0] ADDR_LINK_STATUS = {IDX_LINK_STATUS, 2'b00};
  localparam logic [7:0] RST_SYNC_HEADER_MODE = 8'h00;
  localparam logic [7:0] RST_SYNC_REQUEST_THRESHOLD = 8'h03;
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
  localparam int SH_SEL_W = 2;
  localparam int THRESH_W = 5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int ST_SYNC_BIT = 0;
  localparam int ST_ALIGN_BIT = 1;
  localparam int ST_REQ_BIT = 2;
  localparam int SYNC_WORD_BITS = 32;
  localparam logic [31:0] SYNC_WORD_CRC_BASE = 32'h0000_0000;
  localparam logic [31:0] FEC_SEED = 32'h0000_0001;

  typedef struct packed {
    logic [1:0] kind;     // 0 crc-12, 2 fec, 3 none (8b/10b or reserved)
    logic [11:0] check;
    logic [17:0] command; // always zero: idle headers; keeps the word at 32 bits
  } slsc_sync_word_t;
endpackage

/* File: hw/slsc_fifo.sv */
// small valid/ready fifo for the sync word stream
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ns
module slsc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready_o = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

/* File: hw/slsc_top.sv */
// sync header control and sync request qualifier for the serial link
// assumes clk_sys_i is the link clock (also the sync sample rate) and sync_n_i is synchronous
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - header select 0 sends a crc-12 check and 2 sends fec, 1 and 3 are reserved.
// - header select only applies in 64b/66b mode and each sync word carries 32 bits.
// - every command field of the sync word is zero so idle headers are sent.
// - the sync input is sampled once per link clock cycle.
// - a request is recognised after threshold plus one consecutive low samples.
// - shorter low periods are error reports and are ignored.
// - the threshold register resets to 3.
// - the header select register resets to 0.
// - a status bit reads 0 while sync is low and 1 while it is high.
module slsc_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_n_i,
  input wire logic multiblock_i,
  output logic sync_word_valid_o,
  input wire logic sync_word_ready_i,
  output logic [31:0] sync_word_o,
  output logic align_restart_o,
  output logic aligning_o
);
  typedef enum logic [1:0] {LS_IDLE, LS_ALIGN, LS_DATA} slsc_state_t;
  slsc_state_t state;
  logic [1:0] sync_header_select;
  logic [4:0] sync_request_threshold;
  logic link_enable;
  logic link_mode_select;
  logic [4:0] low_count;
  logic sync_seen;
  logic sync_request;
  logic setup;
  logic [31:0] next_prdata;
  logic addr_ok;
  logic cfg_locked;
  slsc_pkg::slsc_sync_word_t next_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic [11:0] crc_acc;
  logic [31:0] fec_acc;

  assign setup = psel && !penable;
  assign cfg_locked = link_enable;

  always_comb begin
    addr_ok = 1'b1;
    next_prdata = '0;
    unique case (paddr[13:0])
      slsc_pkg::ADDR_SYNC_HEADER_MODE: next_prdata[1:0] = sync_header_select;
      slsc_pkg::ADDR_SYNC_REQUEST_THRESHOLD: next_prdata[4:0] = sync_request_threshold;
      slsc_pkg::ADDR_LINK_CTRL: next_prdata[1:0] = {link_mode_select, link_enable};
      slsc_pkg::ADDR_LINK_STATUS: begin
        next_prdata[slsc_pkg::ST_SYNC_BIT] = sync_seen;
        next_prdata[slsc_pkg::ST_ALIGN_BIT] = state == LS_ALIGN;
        next_prdata[slsc_pkg::ST_REQ_BIT] = sync_request;
      end
      default: addr_ok = 1'b0;
    endcase
    if (paddr[15:14] != 2'b00) addr_ok = 1'b0;
  end

  // no wait states: answer in the cycle after setup
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // writes land at the completing edge; locked config writes are dropped
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_header_select <= slsc_pkg::RST_SYNC_HEADER_MODE[1:0];
      sync_request_threshold <= slsc_pkg::RST_SYNC_REQUEST_THRESHOLD[4:0];
      link_enable <= 1'b0;
      link_mode_select <= 1'b1;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr[13:0] == slsc_pkg::ADDR_SYNC_HEADER_MODE && !cfg_locked) begin
        sync_header_select <= pwdata[1:0];
      end
      if (paddr[13:0] == slsc_pkg::ADDR_SYNC_REQUEST_THRESHOLD && !cfg_locked) begin
        sync_request_threshold <= pwdata[4:0];
      end
      if (paddr[13:0] == slsc_pkg::ADDR_LINK_CTRL) begin
        link_enable <= pwdata[slsc_pkg::CTRL_EN_BIT];
        if (!cfg_locked) link_mode_select <= pwdata[slsc_pkg::CTRL_MODE_BIT];
      end
    end
  end

  // one sample per link clock; a low run must reach threshold+1 samples
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_seen <= 1'b1;
      low_count <= '0;
      sync_request <= 1'b0;
    end else begin
      sync_seen <= sync_n_i;
      sync_request <= 1'b0;
      if (sync_n_i || !link_enable) begin
        low_count <= '0;
      end else begin
        if (low_count == sync_request_threshold) begin
          sync_request <= 1'b1;
        end
        if (low_count != 5'h1F) low_count <= low_count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= LS_IDLE;
      align_restart_o <= 1'b0;
      aligning_o <= 1'b0;
    end else begin
      align_restart_o <= 1'b0;
      unique case (state)
        LS_IDLE: if (link_enable) begin
          state <= LS_ALIGN;
          align_restart_o <= 1'b1;
        end
        LS_ALIGN: if (!link_enable) state <= LS_IDLE;
          else if (sync_seen) state <= LS_DATA;
        LS_DATA: if (!link_enable) state <= LS_IDLE;
          else if (sync_request) begin
            state <= LS_ALIGN;
            align_restart_o <= 1'b1;
          end
      endcase
      aligning_o <= link_enable && (state != LS_DATA);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      crc_acc <= 12'h000;
      fec_acc <= slsc_pkg::FEC_SEED;
    end else if (multiblock_i && fifo_in_ready) begin
      crc_acc <= {crc_acc[10:0], ^crc_acc} ^ 12'h80F;
      fec_acc <= {fec_acc[30:0], fec_acc[31] ^ fec_acc[21] ^ fec_acc[1] ^ fec_acc[0]};
    end
  end

  always_comb begin
    next_word = '0;
    next_word.command = '0;
    next_word.kind = 2'h3;
    if (link_mode_select) begin
      unique case (sync_header_select)
        slsc_pkg::SH_CRC12: begin
          next_word.kind = slsc_pkg::SH_CRC12;
          next_word.check = crc_acc;
        end
        slsc_pkg::SH_FEC: begin
          next_word.kind = slsc_pkg::SH_FEC;
          next_word.check = fec_acc[11:0];
        end
        default: next_word.kind = 2'h3;
      endcase
    end
  end

  // back-pressure: a full fifo holds the check generators
  slsc_fifo #(.WIDTH(slsc_pkg::SYNC_WORD_BITS), .DEPTH(8)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(multiblock_i && link_enable && state == LS_DATA),
    .in_ready_o(fifo_in_ready),
    .in_data_i(next_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(sync_word_ready_i && !sync_word_valid_o),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_word_valid_o <= 1'b0;
      sync_word_o <= 32'h0000_0000;
    end else if (sync_word_valid_o) begin
      if (sync_word_ready_i) sync_word_valid_o <= 1'b0;
    end else if (fifo_out_valid && sync_word_ready_i) begin
      sync_word_valid_o <= 1'b1;
      sync_word_o <= fifo_out_data;
    end
  end

  a_thresh_reset: assert property (@(posedge clk_sys_i) $fell(rst_i)
    |-> sync_request_threshold == 5'h03) else $error("threshold reset wrong");
  a_mode_reset: assert property (@(posedge clk_sys_i) $fell(rst_i)
    |-> sync_header_select == 2'h0) else $error("header select reset wrong");
  a_req_qualify: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sync_request |-> $past(low_count) == sync_request_threshold && $past(!sync_n_i))
    else $error("request without enough low samples");
  a_short_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(sync_n_i) |-> !sync_request) else $error("short low run raised request");
  a_sync_status: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sync_seen == $past(sync_n_i)) else $error("sync status stale");
  a_lock_cfg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(link_enable) && link_enable |-> $stable(sync_request_threshold)
    && $stable(sync_header_select)) else $error("config changed while enabled");
  a_idle_command: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sync_word_valid_o |-> sync_word_o[17:0] == 18'h0) else $error("command not idle");
  a_restart_req: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == LS_DATA && sync_request && link_enable |=> align_restart_o && state == LS_ALIGN)
    else $error("request did not restart alignment");
  a_mode_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !link_mode_select |-> next_word.kind == 2'h3) else $error("header outside 64b66b");
  a_kind_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    link_mode_select && sync_header_select == 2'h2 |-> next_word.kind == 2'h2)
    else $error("fec not selected");
  a_sample_rate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sync_n_i && link_enable && $past(!sync_n_i) && $past(link_enable)
    && $past(low_count) != 5'h1F |-> low_count == $past(low_count) + 5'h01)
    else $error("low run not counted each cycle");
endmodule

/* File: verif/slsc_rx_model.sv */
// receiver-side model: drives the sync request line and accepts sync words
// assumes the bench commands every low run and every stall
`timescale 1ns/1ns
module slsc_rx_model (
  input wire logic clk_sys_i,
  input wire logic stall_i,
  output logic sync_n_o,
  output logic ready_o
);
  initial sync_n_o = 1'b1;
  assign ready_o = !stall_i;
  // short low runs are error reports; sent only when the bench asks for one
  task automatic low(input int n);
    sync_n_o <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    sync_n_o <= 1'b1;
  endtask
endmodule

/* File: verif/test_serial_link_sync_control.sv */
// self-checking bench for the sync control block
// assumes the receiver model drives the sync line and the word consumer
`timescale 1ns/1ns
module test_serial_link_sync_control;
  localparam logic [15:0] HM = {2'b00, slsc_pkg::ADDR_SYNC_HEADER_MODE};
  localparam logic [15:0] TH = {2'b00, slsc_pkg::ADDR_SYNC_REQUEST_THRESHOLD};
  localparam logic [15:0] CT = {2'b00, slsc_pkg::ADDR_LINK_CTRL};
  localparam logic [15:0] ST = {2'b00, slsc_pkg::ADDR_LINK_STATUS};
  logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, sync_word_o, bad_count, total_checks, rs, er, cyc;
  logic sync_n_i, multiblock_i, sync_word_valid_o, sync_word_ready_i;
  logic align_restart_o, aligning_o, stall;
  logic [33:0] aq[$];
  logic [1:0] wq[$];
  logic [7:0] rnd;
  logic [4:0] thr;
  slsc_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_n_i(sync_n_i), .multiblock_i(multiblock_i),
    .sync_word_valid_o(sync_word_valid_o), .sync_word_ready_i(sync_word_ready_i),
    .sync_word_o(sync_word_o), .align_restart_o(align_restart_o), .aligning_o(aligning_o));
  slsc_rx_model rx (.clk_sys_i(clk_sys_i), .stall_i(stall), .sync_n_o(sync_n_i),
    .ready_o(sync_word_ready_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %0t ns: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held until pready is sampled high; the slave sets the pace
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    aq.push_back({w, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task automatic mb(input logic [1:0] k);
    wq.push_back(k);
    multiblock_i <= 1'b1;
    @(posedge clk_sys_i);
    multiblock_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_data;
    int n;
    repeat (3) @(posedge clk_sys_i);
    for (n = 0; n < 200 && aligning_o !== 1'b0; n++) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i) begin
    if (psel && penable && pready === 1'b1) begin
      logic [33:0] e;
      e = aq.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) check(prdata, e[31:0]);
    end
    if (sync_word_valid_o === 1'b1 && sync_word_ready_i === 1'b1) begin
      check(sync_word_o & 32'hC003FFFF, {wq.pop_front(), 30'h0});
    end
    if (align_restart_o === 1'b1) rs <= rs + 32'h1;
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4E20) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    {psel, penable, pwrite, multiblock_i, stall} = 5'h00;
    {paddr, pwdata, bad_count, total_checks, rs, er, cyc} = 0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(HM, 32'h0);
    rd(TH, 32'h3);
    apb(1'b0, 16'h0900, 32'h0, {1'b1, 32'h0});
    fork
      rx.low(8);
      begin
        repeat (3) @(posedge clk_sys_i);
        rd(ST, 32'h0);
      end
    join
    // the status bit lags the pin by one sample
    @(posedge clk_sys_i);
    rd(ST, 32'h1);
    rnd = lfsr(8'h62);
    thr = rnd[4:0] | 5'h01;
    wr(TH, {27'h0, thr});
    wr(HM, {30'h0, slsc_pkg::SH_FEC});
    wr(CT, 32'h3);
    er = 32'h1;
    wait_data;
    wr(TH, {27'h0, ~thr});
    rd(TH, {27'h0, thr});
    // consumer stalls while a full buffer's worth of words queues up
    stall <= 1'b1;
    repeat (8) mb(slsc_pkg::SH_FEC);
    repeat (5) @(posedge clk_sys_i);
    stall <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rx.low(thr);
    repeat (5) @(posedge clk_sys_i);
    check(rs, er);
    rx.low(thr + 1);
    repeat (5) @(posedge clk_sys_i);
    er++;
    check(rs, er);
    wait_data;
    for (int m = 0; m < 4; m++) begin
      wr(CT, 32'h0);
      wr(HM, m);
      rd(HM, m);
      wr(CT, 32'h3);
      er++;
      wait_data;
      mb(m == 0 ? 2'h0 : (m == 2 ? 2'h2 : 2'h3));
    end
    // 8b/10b mode: header select has no effect
    wr(CT, 32'h0);
    wr(HM, 32'h2);
    wr(CT, 32'h1);
    er++;
    wait_data;
    mb(2'h3);
    repeat (30) @(posedge clk_sys_i);
    check(wq.size(), 32'h0);
    check(rs, er);
    close_out;
  end
endmodule
